// File: rtl/ust_pkg.sv
// Constants for the USB frame token threshold and configuration block.
// Assumes a single 125 MHz system clock and an AHB-Lite register bus.
// How it works
// - Hold eight-bit count, ten plus packet size.
// - Count acts only in host role.
// - Config bit 7 runs eye-pattern test.
// - Config bit 6 enables active-low drive indicator.
// - Tristate control forces indicator active always.
// - Config bit 4 halts module during idle.
package ust_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] UST_THRESH_OFS = 8'h00;
  localparam logic [7:0] UST_CFG1_OFS = 8'h04;
  localparam logic [7:0] UST_CFG2_OFS = 8'h08;
  localparam logic [7:0] UST_STAT_OFS = 8'h0C;
  // ==========================================================
  // Field positions
  localparam int UST_EYE_BIT = 7;
  localparam int UST_MON_BIT = 6;
  localparam int UST_SIDL_BIT = 4;
  localparam int UST_TRIS_BIT = 0;
  localparam int UST_STAT_HOST_BIT = 0;
  localparam int UST_STAT_RUN_BIT = 1;
  localparam int UST_STAT_ALLOW_BIT = 2;
  localparam int UST_STAT_EYE_BIT = 3;
  localparam int UST_STAT_OE_BIT = 4;
  // ==========================================================
  // Reset values and constants
  localparam logic [7:0] UST_THRESH_RST = 8'h00;
  localparam logic [7:0] UST_CFG_RST = 8'h00;
  localparam logic [7:0] UST_THRESH_BASE = 8'h0A;
  localparam logic [1:0] UST_HTRANS_NONSEQ = 2'h2;
  localparam int UST_COUNT_W = 8;
endpackage

// File: rtl/ust_ctl_if.sv
// Interface carrying configuration from the register file to the core.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface ust_ctl_if;
  logic [7:0] sof_threshold_count;
  logic eye_pattern_test_enable;
  logic drive_indicator_monitor_enable;
  logic stop_in_idle;
  logic transceiver_tristate_control;
  logic run;
  logic token_allowed;
  logic eye_active;
  logic oe_active;
  modport regs
  (
    output sof_threshold_count, eye_pattern_test_enable, drive_indicator_monitor_enable,
    output stop_in_idle, transceiver_tristate_control,
    input run, token_allowed, eye_active, oe_active
  );
  modport core
  (
    input sof_threshold_count, eye_pattern_test_enable, drive_indicator_monitor_enable,
    input stop_in_idle, transceiver_tristate_control,
    output run, token_allowed, eye_active, oe_active
  );
endinterface

// File: rtl/ust_core.sv
// Link-side gating: token threshold, indicator, eye test, idle stop.
// Assumes config comes from registers on the same clock.
`timescale 1ns/1ps
module ust_core
  import ust_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  ust_ctl_if.core ctl,
  input wire logic host_mode,
  input wire logic cpu_idle,
  input wire logic [15:0] bytes_to_sof,
  input wire logic line_drive,
  output logic oe_n
);
  import ust_pkg::*;

  typedef struct packed
  {
    logic oe_n;
  } ust_core_s;

  ust_core_s st_reg;
  ust_core_s st_next;

  // ==========================================================
  // Gating terms
  always_comb
  begin
    ctl.run = !(ctl.stop_in_idle && cpu_idle);
    ctl.token_allowed = ctl.run && host_mode &&
      (bytes_to_sof >= {8'h00, ctl.sof_threshold_count});
    ctl.eye_active = ctl.run && ctl.eye_pattern_test_enable;
    ctl.oe_active = ctl.transceiver_tristate_control ||
      (ctl.drive_indicator_monitor_enable && ctl.run && (line_drive || ctl.eye_active));
    st_next = st_reg;
    st_next.oe_n = !ctl.oe_active;
  end

  // Indicator is registered so the pin never glitches
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_reg <= '{oe_n: 1'b1};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign oe_n = st_reg.oe_n;
endmodule

// File: rtl/ust_top.sv
// Top: AHB-Lite register file for the threshold and config registers.
// Assumes a single AHB-Lite master and one slave; zero-wait answers.
//
// Chosen here: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
module ust_top
  import ust_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic HOST_MODE,
  input wire logic CPU_IDLE,
  input wire logic [15:0] BYTES_TO_SOF,
  input wire logic LINE_DRIVE,
  output logic TOKEN_ALLOWED,
  output logic EYE_TEST_ACTIVE,
  output logic MODULE_RUN,
  output logic OE_N
);
  import ust_pkg::*;

  typedef struct packed
  {
    logic [7:0] thresh;
    logic eye;
    logic mon;
    logic sidl;
    logic tris;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
  } ust_top_s;

  ust_top_s st_reg;
  ust_top_s st_next;
  ust_ctl_if ctl ();

  // Status word assembled from live core state
  function automatic logic [31:0] rd_mux(input ust_top_s s, input logic [7:0] a, input logic [4:0] stv);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      UST_THRESH_OFS: v[7:0] = s.thresh;
      UST_CFG1_OFS:
      begin
        v[UST_EYE_BIT] = s.eye;
        v[UST_MON_BIT] = s.mon;
        v[UST_SIDL_BIT] = s.sidl;
      end
      UST_CFG2_OFS: v[UST_TRIS_BIT] = s.tris;
      UST_STAT_OFS: v[4:0] = stv;
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  logic take;
  logic [4:0] stat_v;

  // ==========================================================
  // Bus decode and register update
  always_comb
  begin
    take = HSEL && HREADY && (HTRANS == UST_HTRANS_NONSEQ);
    stat_v = 5'h00;
    stat_v[UST_STAT_HOST_BIT] = HOST_MODE;
    stat_v[UST_STAT_RUN_BIT] = ctl.run;
    stat_v[UST_STAT_ALLOW_BIT] = ctl.token_allowed;
    stat_v[UST_STAT_EYE_BIT] = ctl.eye_active;
    stat_v[UST_STAT_OE_BIT] = ctl.oe_active;
    st_next = st_reg;
    st_next.wr_pend = 1'b0;
    // Write data arrive in the data phase, one cycle after the address
    if (st_reg.wr_pend)
    begin
      case (st_reg.wr_addr)
        UST_THRESH_OFS: st_next.thresh = HWDATA[7:0];
        UST_CFG1_OFS:
        begin
          st_next.eye = HWDATA[UST_EYE_BIT];
          st_next.mon = HWDATA[UST_MON_BIT];
          st_next.sidl = HWDATA[UST_SIDL_BIT];
        end
        UST_CFG2_OFS: st_next.tris = HWDATA[UST_TRIS_BIT];
        default: st_next.tris = st_reg.tris;
      endcase
    end
    if (take)
    begin
      st_next.wr_pend = HWRITE;
      st_next.wr_addr = {HADDR[7:2], 2'b00};
      // Read mux sees a write landing in this same cycle, so write-then-read returns new data
      st_next.rdata = HWRITE ? 32'h0000_0000 : rd_mux(st_next, {HADDR[7:2], 2'b00}, stat_v);
    end
  end

  // State register; all fields clear at reset
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      st_reg <= '{thresh: UST_THRESH_RST, eye: 1'b0, mon: 1'b0, sidl: 1'b0, tris: 1'b0,
                  wr_pend: 1'b0, wr_addr: 8'h00, rdata: 32'h0000_0000};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // Config to core
  assign ctl.sof_threshold_count = st_reg.thresh;
  assign ctl.eye_pattern_test_enable = st_reg.eye;
  assign ctl.drive_indicator_monitor_enable = st_reg.mon;
  assign ctl.stop_in_idle = st_reg.sidl;
  assign ctl.transceiver_tristate_control = st_reg.tris;

  ust_core u_core
  (
    .clk(CLK_SYS),
    .rst(RST),
    .ctl(ctl),
    .host_mode(HOST_MODE),
    .cpu_idle(CPU_IDLE),
    .bytes_to_sof(BYTES_TO_SOF),
    .line_drive(LINE_DRIVE),
    .oe_n(OE_N)
  );

  // Zero-wait slave, always OKAY
  assign HRDATA = st_reg.rdata;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign TOKEN_ALLOWED = ctl.token_allowed;
  assign EYE_TEST_ACTIVE = ctl.eye_active;
  assign MODULE_RUN = ctl.run;
endmodule

// File: tb/ust_chk.sv
// Port checker for ust_top.
// Assumes a bind to ust_top; keeps its own copy of register writes.
`timescale 1ns/1ps
module ust_chk
  import ust_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic HOST_MODE,
  input wire logic CPU_IDLE,
  input wire logic [15:0] BYTES_TO_SOF,
  input wire logic LINE_DRIVE,
  input wire logic TOKEN_ALLOWED,
  input wire logic EYE_TEST_ACTIVE,
  input wire logic MODULE_RUN,
  input wire logic OE_N
);
  logic wv_reg;
  logic [7:0] wa_reg, th_reg, c1_reg;
  logic tr_reg;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  // ==========
  // Write copy: data lands one cycle after the address
  always_ff @(posedge CLK_SYS or posedge RST)
    if (RST)
    begin
      {wv_reg, wa_reg, th_reg, c1_reg, tr_reg} <= '0;
    end
    else
    begin
      wv_reg <= HSEL && HREADY && HTRANS == UST_HTRANS_NONSEQ && HWRITE;
      wa_reg <= {HADDR[7:2], 2'b00};
      if (wv_reg && wa_reg == UST_THRESH_OFS) th_reg <= HWDATA[7:0];
      if (wv_reg && wa_reg == UST_CFG1_OFS) c1_reg <= HWDATA[7:0];
      if (wv_reg && wa_reg == UST_CFG2_OFS) tr_reg <= HWDATA[0];
    end
  property p_tok; TOKEN_ALLOWED == (MODULE_RUN && HOST_MODE && BYTES_TO_SOF >= {8'h00, th_reg}); endproperty
  a_tok: assert property (p_tok) else $error("token gate");
  property p_host; !HOST_MODE |-> !TOKEN_ALLOWED; endproperty
  a_host: assert property (p_host) else $error("token outside host");
  property p_run; MODULE_RUN == !(c1_reg[UST_SIDL_BIT] && CPU_IDLE); endproperty
  a_run: assert property (p_run) else $error("idle stop");
  property p_eye; EYE_TEST_ACTIVE == (MODULE_RUN && c1_reg[UST_EYE_BIT]); endproperty
  a_eye: assert property (p_eye) else $error("eye test");
  property p_oe; ##1 OE_N == !$past(tr_reg || (c1_reg[UST_MON_BIT] && MODULE_RUN && (LINE_DRIVE || EYE_TEST_ACTIVE))); endproperty
  a_oe: assert property (p_oe) else $error("drive indicator");
  property p_tris; tr_reg |=> !OE_N; endproperty
  a_tris: assert property (p_tris) else $error("tristate force");
  property p_rdy; HREADYOUT; endproperty
  a_rdy: assert property (p_rdy) else $error("wait state");
  property p_resp; !HRESP; endproperty
  a_resp: assert property (p_resp) else $error("bus error");
endmodule
bind ust_top ust_chk u_chk (.*);

// File: tb/ust_link_model.sv
// Link side model: byte countdown to frame start, line drive.
// Assumes one byte time per clock.
`timescale 1ns/1ps
module ust_link_model #(
  parameter logic [15:0] FRAME_LEN = 16'h00FF
) (
  input wire logic clk,
  input wire logic rst,
  output logic [15:0] bytes_to_sof,
  output logic line_drive
);
  // ==========
  // Countdown restarts at each frame start
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      bytes_to_sof <= FRAME_LEN;
      line_drive <= 1'b0;
    end
    else
    begin
      bytes_to_sof <= (bytes_to_sof == 16'h0000) ? FRAME_LEN : bytes_to_sof - 16'h0001;
      line_drive <= bytes_to_sof[3];
    end
endmodule

// File: tb/test_usb_sof_threshold_and_config.sv
// Bench for ust_top over AHB-Lite.
// Assumes the link model drives the frame inputs.
`timescale 1ns/1ps
module test_usb_sof_threshold_and_config;
  import ust_pkg::*;
  logic clk = 0, rst = 1, hsel = 0, hwrite = 0, host = 0, idle = 0;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  logic rdy, resp, drv, tok, eye, run, oe_n, d;
  logic [15:0] b2s;
  int num_errors = 0, check_count = 0;
  always #4 clk = !clk;
  ust_link_model link (.clk(clk), .rst(rst), .bytes_to_sof(b2s), .line_drive(drv));
  ust_top dut (.CLK_SYS(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(rdy), .HRDATA(hrdata), .HREADYOUT(rdy), .HRESP(resp),
    .HOST_MODE(host), .CPU_IDLE(idle), .BYTES_TO_SOF(b2s), .LINE_DRIVE(drv), .TOKEN_ALLOWED(tok),
    .EYE_TEST_ACTIVE(eye), .MODULE_RUN(run), .OE_N(oe_n));
  task automatic end_sim;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, e);
    check_count++;
    if (s !== e)
    begin
      num_errors++;
      $display("ERROR %s exp %h seen %h", n, e, s);
    end
  endtask
  // One single transfer; waits for ready in both phases
  task automatic xf(input logic w, input logic [31:0] a, d);
    @(posedge clk);
    hsel <= 1;
    htrans <= UST_HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (rdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (rdy !== 1'b1);
    r = hrdata;
  endtask
  task automatic wb(input logic [15:0] v);
    @(negedge clk);
    while (b2s !== v) @(negedge clk);
  endtask
  initial
  begin
    #100000;
    num_errors++;
    end_sim;
  end
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 0;
    xf(0, 32'h0, 0);
    chk("thr reset", r, 0);
    xf(1, 32'h0, 32'hFFFFFF4A);
    xf(0, 32'h0, 0);
    chk("thr", r, 32'h4A);
    xf(1, 32'h4, '1);
    xf(0, 32'h4, 0);
    chk("cfg1", r, 32'hD0);
    xf(0, 32'hC, 0);
    chk("status", r, 32'h1A);
    xf(1, 32'h1C, '1);
    xf(0, 32'h1C, 0);
    chk("unmapped", r, 0);
    idle <= 1;
    @(negedge clk);
    chk("stopped", {run, eye}, 0);
    @(posedge clk);
    idle <= 0;
    host <= 1;
    wb(16'h004A);
    chk("eye", eye, 1);
    chk("tok at thr", tok, 1);
    wb(16'h0049);
    chk("tok below", tok, 0);
    // Count well above threshold, so only the role can block the token
    @(posedge clk);
    host <= 0;
    wb(16'h00F0);
    chk("tok device", tok, 0);
    xf(1, 32'h4, 32'h40);
    idle <= 1;
    @(negedge clk);
    chk("run in idle", run, 1);
    // Indicator follows the line drive of the cycle before
    repeat (40)
    begin
      d = drv;
      @(negedge clk);
      chk("oe mon", oe_n, !d);
    end
    xf(1, 32'h4, 0);
    @(negedge clk);
    repeat (16)
    begin
      @(negedge clk);
      chk("oe off", oe_n, 1);
    end
    xf(1, 32'h8, 1);
    repeat (2) @(negedge clk);
    chk("oe forced", oe_n, 0);
    // Second reset in mid-run clears the force again
    @(posedge clk);
    rst <= 1;
    @(posedge clk);
    rst <= 0;
    @(negedge clk);
    chk("oe reset", oe_n, 1);
    xf(0, 32'h8, 0);
    chk("cfg2 reset", r, 0);
    end_sim;
  end
endmodule
